// >>> hw/dsrc_ctrl.sv
// DDR3 automatic self-refresh sequencer with refresh-rate limiter.
// Assumes the command scheduler shares clk and holds cmd_pending while
// reads or writes are queued, and only executes them while exec_enable.
// Idle delay codes of 0x9 and up are floored at 4096 cycles at any scale.
`timescale 1ns/1ps

module dsrc_ctrl
    import dsrc_pkg::*;
#(
    parameter int IDLE_SCALE_SHIFT = 3             // Idle cycles = 1 << (delay + this)
) (
    input  wire logic                 clk,                // 10 MHz DDR-side clock
    input  wire logic                 rst,                // Synchronous, active high
    input  wire logic [LP_SEL_W-1:0]  low_power_select,   // Low-power mode select
    input  wire logic [SR_DLY_W-1:0]  self_refresh_idle_delay, // Idle delay code
    input  wire logic                 cmd_pending,        // Read/write queued
    output logic                      exec_enable,        // Scheduler may issue commands
    output logic                      refresh_cmd,        // One-cycle refresh command
    output logic                      sr_enter_cmd,       // One-cycle self-refresh entry
    output logic                      sr_exit_cmd,        // One-cycle self-refresh exit
    output logic                      in_self_refresh     // Memory is in self-refresh
);

    // ----------------------------------------------------------------
    // Mode decode and idle target
    // ----------------------------------------------------------------
    wire        auto_sr_on  = (low_power_select == LP_AUTO_SR);
    wire        delay_valid = (self_refresh_idle_delay != SR_DLY_OFF);
    wire [4:0]  shift_amt   = 5'(self_refresh_idle_delay) + 5'(IDLE_SCALE_SHIFT);
    wire [IDLE_CNT_W-1:0] idle_scaled = IDLE_CNT_W'(1) << shift_amt;
    // The floor keeps safe codes safe even when the scale shift is lowered
    wire                  safe_code   = (self_refresh_idle_delay >= SR_DLY_SAFE);
    wire                  below_floor = (idle_scaled < IDLE_CNT_W'(IDLE_SAFE_CYC));
    wire [IDLE_CNT_W-1:0] idle_target = (safe_code && below_floor)
                                      ? IDLE_CNT_W'(IDLE_SAFE_CYC) : idle_scaled;

    dsrc_state_e          state_reg;
    dsrc_state_e          state_next;
    logic [IDLE_CNT_W-1:0] idle_cnt_reg;
    logic [IDLE_CNT_W-1:0] idle_cnt_next;

    // ----------------------------------------------------------------
    // Refresh window limiter
    // ----------------------------------------------------------------
    // A shift history is used instead of a counter so the window truly
    // slides; a fixed-bucket count would allow 32 across a boundary.
    logic [REF_WIN_CYC-1:0] hist_reg;
    logic [REF_CNT_W-1:0]   ref_cnt_reg;
    logic                   ref_fire;

    wire                 oldest    = hist_reg[REF_WIN_CYC-1];
    wire [REF_CNT_W-1:0] cnt_after = ref_cnt_reg - REF_CNT_W'(oldest);
    wire                 ref_ok    = (cnt_after < REF_CNT_W'(REF_MAX_IN_WIN));
    wire [REF_CNT_W-1:0] ref_cnt_next = cnt_after + REF_CNT_W'(ref_fire);

    always_ff @(posedge clk) begin
        if (rst) begin
            hist_reg    <= '0;
            ref_cnt_reg <= '0;
        end else begin
            hist_reg    <= {hist_reg[REF_WIN_CYC-2:0], ref_fire};
            ref_cnt_reg <= ref_cnt_next;
        end
    end

    // ----------------------------------------------------------------
    // Idle counter
    // ----------------------------------------------------------------
    wire idle_done  = (idle_cnt_reg >= idle_target);
    wire idle_count = (state_reg == ST_ACTIVE) && auto_sr_on && delay_valid;

    always_comb begin
        idle_cnt_next = idle_cnt_reg;
        if (!idle_count || cmd_pending) begin
            idle_cnt_next = IDLE_CNT_RST;
        end else if (!idle_done) begin
            idle_cnt_next = idle_cnt_reg + IDLE_CNT_W'(1);
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        ref_fire   = 1'b0;
        case (state_reg)
            ST_ACTIVE: begin
                if (idle_count && !cmd_pending && idle_done) begin
                    state_next = ST_ENTER_REF;
                end
            end
            ST_ENTER_REF: begin
                // Entry is abandoned if work shows up while waiting for budget
                if (cmd_pending || !auto_sr_on) begin
                    state_next = ST_ACTIVE;
                end else if (ref_ok) begin
                    ref_fire   = 1'b1;
                    state_next = ST_ENTER_SR;
                end
            end
            ST_ENTER_SR: begin
                state_next = ST_SELF_REF;
            end
            ST_SELF_REF: begin
                if (cmd_pending || !auto_sr_on) begin
                    state_next = ST_EXIT_SR;
                end
            end
            ST_EXIT_SR: begin
                state_next = ST_EXIT_REF;
            end
            ST_EXIT_REF: begin
                // Wake latency grows when the window is full; the limit wins
                if (ref_ok) begin
                    ref_fire   = 1'b1;
                    state_next = ST_ACTIVE;
                end
            end
            default: begin
                state_next = ST_ACTIVE;
            end
        endcase
    end

    wire exec_next = (state_next == ST_ACTIVE);
    wire sre_next  = (state_reg == ST_ENTER_SR);
    wire srx_next  = (state_next == ST_EXIT_SR) && (state_reg == ST_SELF_REF);
    wire insr_next = (state_next == ST_ENTER_SR) || (state_next == ST_SELF_REF)
                  || (state_next == ST_EXIT_SR) || sre_next;

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg       <= ST_ACTIVE;
            idle_cnt_reg    <= IDLE_CNT_RST;
            exec_enable     <= 1'b1;
            refresh_cmd     <= 1'b0;
            sr_enter_cmd    <= 1'b0;
            sr_exit_cmd     <= 1'b0;
            in_self_refresh <= 1'b0;
        end else begin
            state_reg       <= state_next;
            idle_cnt_reg    <= idle_cnt_next;
            exec_enable     <= exec_next;
            refresh_cmd     <= ref_fire;
            sr_enter_cmd    <= sre_next;
            sr_exit_cmd     <= srx_next;
            in_self_refresh <= insr_next;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    AST_ENTRY_REF: assert property (@(posedge clk) disable iff (rst)
        sr_enter_cmd |-> $past(refresh_cmd))
        else $error("Self-refresh entry without preceding refresh");

    AST_EXIT_REF: assert property (@(posedge clk) disable iff (rst)
        sr_exit_cmd |-> ##[2:160] refresh_cmd)
        else $error("Self-refresh exit not followed by refresh");

    AST_WIN_LIMIT: assert property (@(posedge clk) disable iff (rst)
        ref_cnt_reg <= REF_CNT_W'(REF_MAX_IN_WIN))
        else $error("More than 16 refreshes in window");

    AST_WAKE: assert property (@(posedge clk) disable iff (rst)
        (state_reg == ST_SELF_REF && cmd_pending) |=> sr_exit_cmd)
        else $error("Pending command did not wake memory");

    AST_MODE_EXIT: assert property (@(posedge clk) disable iff (rst)
        (state_reg == ST_SELF_REF && !auto_sr_on) |=> sr_exit_cmd)
        else $error("Leaving automatic mode did not wake memory");

    AST_EXIT_PULSE: assert property (@(posedge clk) disable iff (rst)
        sr_exit_cmd |=> !sr_exit_cmd && !in_self_refresh)
        else $error("Exit pulse too long or self-refresh level stuck");

    AST_EXEC_RISE: assert property (@(posedge clk) disable iff (rst)
        $rose(exec_enable) |-> (refresh_cmd || ($past(state_reg) == ST_ENTER_REF)))
        else $error("Commands enabled without exit refresh or aborted entry");

    AST_REF_PULSE: assert property (@(posedge clk) disable iff (rst)
        refresh_cmd |=> !refresh_cmd)
        else $error("Refresh command longer than one cycle");

    AST_ABORT: assert property (@(posedge clk) disable iff (rst)
        (state_reg == ST_ENTER_REF && cmd_pending) |=> !refresh_cmd && exec_enable)
        else $error("Aborted entry still issued a refresh");

    AST_SR_LEVEL: assert property (@(posedge clk) disable iff (rst)
        sr_enter_cmd |-> in_self_refresh)
        else $error("Entry pulse without self-refresh level");

    AST_NO_EXEC_SR: assert property (@(posedge clk) disable iff (rst)
        in_self_refresh |-> !exec_enable)
        else $error("Commands enabled while in self-refresh");

    AST_IDLE_WAIT: assert property (@(posedge clk) disable iff (rst)
        (state_reg == ST_ACTIVE && state_next == ST_ENTER_REF) |->
            (idle_cnt_reg >= idle_target)
            && ($past(idle_cnt_reg) == idle_cnt_reg - IDLE_CNT_W'(1)))
        else $error("Self-refresh entered before idle delay");

    AST_SAFE_DLY: assert property (@(posedge clk) disable iff (rst)
        (state_reg == ST_ACTIVE && state_next == ST_ENTER_REF
            && self_refresh_idle_delay >= SR_DLY_SAFE) |->
            idle_cnt_reg >= IDLE_CNT_W'(IDLE_SAFE_CYC))
        else $error("Safe idle delay shorter than 4096 cycles");

    AST_RESTART: assert property (@(posedge clk) disable iff (rst)
        (state_reg == ST_ACTIVE && cmd_pending) |=> idle_cnt_reg == IDLE_CNT_RST)
        else $error("Idle count not restarted by command");

    AST_MODE_OFF: assert property (@(posedge clk) disable iff (rst)
        (!auto_sr_on && state_reg == ST_ACTIVE) |=> state_reg == ST_ACTIVE)
        else $error("Self-refresh started outside automatic mode");

endmodule

// >>> hw/dsrc_pkg.sv
// Constants for the DDR3 automatic self-refresh control block.
// Assumes a single 10 MHz clock shared with the command scheduler.
package dsrc_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 100;
    localparam int TREFI2_NS       = 15600;          // Twice the average refresh interval
    // Longest window, rounded down to whole cycles
    localparam int REF_WIN_CYC     = TREFI2_NS / CLK_PERIOD_NS;
    localparam int REF_MAX_IN_WIN  = 16;
    localparam int REF_CNT_W       = 5;

    // ----------------------------------------------------------------
    // Mode and idle delay fields
    // ----------------------------------------------------------------
    localparam int LP_SEL_W        = 3;
    localparam logic [2:0] LP_AUTO_SR = 3'h2;
    localparam int SR_DLY_W        = 4;
    localparam logic [3:0] SR_DLY_SAFE = 4'h9;
    localparam logic [3:0] SR_DLY_OFF  = 4'h0;
    localparam int IDLE_CNT_W      = 19;
    localparam int IDLE_SAFE_CYC   = 4096;
    localparam logic [18:0] IDLE_CNT_RST = 19'h0_0000;

    // ----------------------------------------------------------------
    // Sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_ACTIVE    = 6'b00_0001,
        ST_ENTER_REF = 6'b00_0010,
        ST_ENTER_SR  = 6'b00_0100,
        ST_SELF_REF  = 6'b00_1000,
        ST_EXIT_SR   = 6'b01_0000,
        ST_EXIT_REF  = 6'b10_0000
    } dsrc_state_e;

endpackage

// >>> verification/dsrc_dram_model.sv
// Memory-side model: follows refresh, entry and exit commands.
// Assumes it shares the controller clock; bad counts broken orders.
`timescale 1ns/1ps
module dsrc_dram_model
    import dsrc_pkg::*;
(
    input  wire logic clk,          // Shared clock
    input  wire logic rst,          // Sync reset
    input  wire logic refresh_cmd,  // Refresh pulse
    input  wire logic sr_enter_cmd, // Entry pulse
    input  wire logic sr_exit_cmd,  // Exit pulse
    output int        bad,          // Violations seen
    output int        peak          // Most refreshes in a window
);
    int   now = 0;
    int   q[$];
    logic in_sr;
    logic ref_d;
    always @(posedge clk) begin
        if (rst) begin
            bad = 0;
            peak = 0;
            in_sr = 1'b0;
            q.delete();
        end else begin
            now++;
            // Sliding window of stamps keeps the figure exact at every edge
            while (q.size() > 0 && q[0] <= now - REF_WIN_CYC) void'(q.pop_front());
            if (refresh_cmd) q.push_back(now);
            if (q.size() > peak) peak = q.size();
            if (q.size() > REF_MAX_IN_WIN) bad++;
            if ((sr_enter_cmd && !ref_d) || (refresh_cmd && in_sr)) bad++;
            if (sr_exit_cmd && !in_sr) bad++;
            if (sr_enter_cmd) in_sr = 1'b1;
            if (sr_exit_cmd) in_sr = 1'b0;
        end
        ref_d = refresh_cmd;
    end
endmodule

// >>> verification/dsrc_ctrl_bench.sv
// Self-checking bench for the self-refresh sequencer.
// Assumes the memory model beside it; idle counts shortened by SH.
`timescale 1ns/1ps
module dsrc_ctrl_bench
    import dsrc_pkg::*;
;
    localparam int SH = 0; // Short idle counts keep the run brief
    logic       clk, rst, cmd_pending, exec_enable, refresh_cmd;
    logic       sr_enter_cmd, sr_exit_cmd, in_self_refresh;
    logic [2:0] low_power_select;
    logic [3:0] self_refresh_idle_delay;
    int         mismatches, checks, bad, peak, n;
    int         cyc = 0;
    dsrc_ctrl #(.IDLE_SCALE_SHIFT(SH)) dut_u (.clk(clk), .rst(rst),
        .low_power_select(low_power_select), .self_refresh_idle_delay(self_refresh_idle_delay),
        .cmd_pending(cmd_pending), .exec_enable(exec_enable), .refresh_cmd(refresh_cmd),
        .sr_enter_cmd(sr_enter_cmd), .sr_exit_cmd(sr_exit_cmd),
        .in_self_refresh(in_self_refresh));
    dsrc_dram_model mem_u (.clk(clk), .rst(rst), .refresh_cmd(refresh_cmd),
        .sr_enter_cmd(sr_enter_cmd), .sr_exit_cmd(sr_exit_cmd), .bad(bad), .peak(peak));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            mismatches++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("mismatches=%0d checks=%0d", mismatches, checks);
        if (mismatches == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic drive(input logic [2:0] m, input logic [3:0] d, input logic c);
        @(posedge clk);
        low_power_select <= m;
        self_refresh_idle_delay <= d;
        cmd_pending <= c;
    endtask
    // Cycles until the chosen pulse; lim+1 means it did not come within lim cycles
    task automatic wait_ev(input int sel, input int lim, output int k);
        logic hit;
        k = 0;
        do begin
            tick();
            k++;
            hit = (sel == 0) ? refresh_cmd : (sel == 1) ? sr_enter_cmd : sr_exit_cmd;
        end while (hit !== 1'b1 && k <= lim);
    endtask
    task automatic s_enter(input logic [3:0] d);
        int idle_exp;
        idle_exp = 1 << (d + SH);
        if (d >= 4'h9 && idle_exp < IDLE_SAFE_CYC) begin
            idle_exp = IDLE_SAFE_CYC;
        end
        drive(3'h2, d, 1'b0);
        wait_ev(0, 5000, n);
        chk(n, idle_exp + 2);
        tick();
        chk({sr_enter_cmd, in_self_refresh, exec_enable}, 3'b110);
    endtask
    task automatic s_wake();
        drive(3'h2, self_refresh_idle_delay, 1'b1);
        tick();
        chk({sr_exit_cmd, refresh_cmd}, 2'b10);
        wait_ev(0, 200, n);
        chk({exec_enable, in_self_refresh}, 2'b10);
    endtask
    task automatic s_restart();
        drive(3'h2, 4'h2, 1'b0);
        tick();
        tick();
        drive(3'h2, 4'h2, 1'b1);
        drive(3'h2, 4'h2, 1'b0);
        wait_ev(0, 40, n);
        chk(n, (1 << (2 + SH)) + 2);
        s_wake();
    endtask
    task automatic s_mode_exit();
        drive(3'h2, 4'h1, 1'b0);
        wait_ev(1, 300, n);
        drive(3'h0, 4'h1, 1'b0);
        wait_ev(2, 300, n);
        chk(n, 1);
        wait_ev(0, 300, n);
        chk({exec_enable, in_self_refresh}, 2'b10);
    endtask
    task automatic s_off();
        for (int m = 0; m < 8; m++) begin
            drive(3'(m), (m == 2) ? 4'h0 : 4'h1, 1'b0);
            wait_ev(0, 20, n);
            chk(n, 21);
            drive(3'(m), 4'h1, 1'b1);
        end
    endtask
    task automatic s_burst();
        // Shortest delay packs refreshes densely so the limiter must act
        repeat (12) begin
            drive(3'h2, 4'h1, 1'b0);
            wait_ev(1, 300, n);
            drive(3'h2, 4'h1, 1'b1);
            wait_ev(0, 300, n);
            chk(exec_enable, 1'b1);
        end
        chk(bad, 0);
        chk(peak, REF_MAX_IN_WIN);
    endtask
    initial begin
        rst = 1'b1;
        cmd_pending = 1'b1;
        low_power_select = 3'h0;
        self_refresh_idle_delay = 4'h0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        tick();
        chk({exec_enable, refresh_cmd, in_self_refresh}, 3'b100);
        drive(3'h2, 4'h2, 1'b1);
        s_enter(4'h2);
        s_wake();
        s_restart();
        s_off();
        s_mode_exit();
        s_burst();
        drive(3'h2, 4'h9, 1'b1);
        s_enter(4'h9);
        s_wake();
        finish_test();
    end
endmodule
